// file: rif_map.vh
// Overview of operation
// - Enabled pending event drives interrupt pin high
// - Flags latch regardless of enables; enables gate the pin, enable bit 0 also gates the abort
// - No-response enable clear keeps receive running
// - Transmit end sets flag bit 7
// - Receive end sets flag bit 6
// - FIFO level flag: tx below 6, rx above 18
// - Receive or transmit error sets bit 4
// - Bit 3: header high, or second byte option
// - Auto acknowledge finish sets bit 1
// - Timer expiry sets bit 0, aborts receive when enable bit 0 is set
// - Flags cleared at power-up and enable low
// - Completed flag register read clears the flags it returned; pin drops once no enabled flag remains
// - Pin high while any enabled flag remains
// - Errors set main flag and sub-flag together
`ifndef RIF_MAP_VH
`define RIF_MAP_VH

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define RIF_IDX_EN1 8'h35
`define RIF_IDX_EN2 8'h36
`define RIF_IDX_F1 8'h37
`define RIF_IDX_F2 8'h38
`define RIF_ADDR_HI 9
`define RIF_ADDR_LO 2

// ----------------------------------------------------------------
// Reset values and implemented-bit masks
// ----------------------------------------------------------------
`define RIF_EN1_RST 8'hF7
`define RIF_EN1_WMASK 8'hFB
`define RIF_EN1_FIXED 8'h04
`define RIF_EN2_RST 8'h40
`define RIF_EN2_WMASK 8'hC7
`define RIF_F1_MASK 8'hFB
`define RIF_F2_MASK 8'hC7
`define RIF_ZERO8 8'h00

// ----------------------------------------------------------------
// Flag bit positions, first register
// ----------------------------------------------------------------
`define RIF_B_TX 7
`define RIF_B_RX 6
`define RIF_B_FIFO 5
`define RIF_B_ERR 4
`define RIF_B_HDR 3
`define RIF_B_AACK 1
`define RIF_B_NORESP 0

// ----------------------------------------------------------------
// Flag bit positions, second register
// ----------------------------------------------------------------
`define RIF_B_ANA 7
`define RIF_B_CMD 6
`define RIF_B_CRC 2
`define RIF_B_LEN 1
`define RIF_B_PRE 0

// ----------------------------------------------------------------
// FIFO thresholds and bus responses
// ----------------------------------------------------------------
`define RIF_TX_LOW_LVL 5'h06
`define RIF_RX_HIGH_LVL 5'h12
`define RIF_RESP_OKAY 2'h0
`define RIF_RESP_SLVERR 2'h2

`endif

// file: rif_sync.v
`timescale 1ns/1ns
`include "rif_map.vh"

// ----------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter
// ----------------------------------------------------------------
module rif_sync #(
  parameter W = 1
) (
  aclk,
  aresetn,
  ce,
  pin_in,
  level_out
);
  input wire aclk;
  input wire aresetn;
  input wire ce;
  input wire [W-1:0] pin_in;
  output reg [W-1:0] level_out;

  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;

  // First stage feeds only the second; change taken once 2 and 3 agree
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_ff <= {W{1'b0}};
      s2_ff <= {W{1'b0}};
      s3_ff <= {W{1'b0}};
      level_out <= {W{1'b0}};
    end
    else if (ce)
    begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      level_out <= (s2_ff == s3_ff) ? s3_ff : level_out;
    end
  end
endmodule // rif_sync

// file: rif_top.v
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ns
`include "rif_map.vh"

// ----------------------------------------------------------------
// Interrupt flags, enables and AXI4-Lite register slave
// ----------------------------------------------------------------
module rif_top #(
  parameter AW = 12,
  parameter FW = 5
) (
  aclk,
  aresetn,
  ce,
  chip_en_pin,
  tx_done,
  rx_done,
  tx_active,
  rx_active,
  fifo_count,
  crc_fault,
  length_fault,
  preamble_fault,
  header_bit_high,
  second_byte_evt,
  direct_fifo_second_byte_option,
  automatic_acknowledge_procedure,
  automatic_acknowledge_procedure_success,
  noresp_expired,
  ana_change,
  cmd_done,
  irq,
  rx_abort,
  s_axi_awaddr,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready
);
  input wire aclk;
  input wire aresetn;
  input wire ce;
  input wire chip_en_pin;
  input wire tx_done;
  input wire rx_done;
  input wire tx_active;
  input wire rx_active;
  input wire [FW-1:0] fifo_count;
  input wire crc_fault;
  input wire length_fault;
  input wire preamble_fault;
  input wire header_bit_high;
  input wire second_byte_evt;
  input wire direct_fifo_second_byte_option;
  input wire automatic_acknowledge_procedure;
  input wire automatic_acknowledge_procedure_success;
  input wire noresp_expired;
  input wire ana_change;
  input wire cmd_done;
  output reg irq;
  output reg rx_abort;
  input wire [AW-1:0] s_axi_awaddr;
  input wire s_axi_awvalid;
  output reg s_axi_awready;
  input wire [31:0] s_axi_wdata;
  input wire [3:0] s_axi_wstrb;
  input wire s_axi_wvalid;
  output reg s_axi_wready;
  output reg [1:0] s_axi_bresp;
  output reg s_axi_bvalid;
  input wire s_axi_bready;
  input wire [AW-1:0] s_axi_araddr;
  input wire s_axi_arvalid;
  output reg s_axi_arready;
  output reg [31:0] s_axi_rdata;
  output reg [1:0] s_axi_rresp;
  output reg s_axi_rvalid;
  input wire s_axi_rready;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [7:0] en1_ff;
  reg [7:0] en2_ff;
  reg [7:0] f1_ff;
  reg [7:0] f2_ff;
  reg [7:0] snap1_ff;
  reg [7:0] snap2_ff;
  reg aw_held_ff;
  reg w_held_ff;
  reg [7:0] waidx_ff;
  reg [7:0] wbyte_ff;
  reg wstrb0_ff;
  reg [7:0] nxt_en1;
  reg [7:0] nxt_en2;
  reg [7:0] nxt_f1;
  reg [7:0] nxt_f2;
  reg [7:0] nxt_snap1;
  reg [7:0] nxt_snap2;
  reg nxt_aw_held;
  reg nxt_w_held;
  reg [7:0] nxt_waidx;
  reg [7:0] nxt_wbyte;
  reg nxt_wstrb0;
  reg nxt_irq;
  reg nxt_rx_abort;
  reg nxt_awready;
  reg nxt_wready;
  reg [1:0] nxt_bresp;
  reg nxt_bvalid;
  reg nxt_arready;
  reg [31:0] nxt_rdata;
  reg [1:0] nxt_rresp;
  reg nxt_rvalid;
  reg [7:0] set1;
  reg [7:0] set2;
  reg [7:0] clr1;
  reg [7:0] clr2;
  reg [7:0] rd_byte;
  reg rd_hit;
  wire chip_en;
  wire aw_take;
  wire w_take;
  wire ar_take;
  wire r_done;
  wire do_write;
  wire any_err;
  wire fifo_level;
  wire [7:0] raidx;

  // ----------------------------------------------------------------
  // Chip enable pin comes from outside the clock domain
  // ----------------------------------------------------------------
  rif_sync #(
    .W(1)
  ) u_en_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pin_in(chip_en_pin),
    .level_out(chip_en)
  );

  // Handshakes; registers are word aligned, low address bits ignored
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign r_done = s_axi_rvalid && s_axi_rready;
  assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign raidx = s_axi_araddr[`RIF_ADDR_HI:`RIF_ADDR_LO];

  // Shared error sources feed main and sub flags alike
  assign any_err = crc_fault || length_fault || preamble_fault;
  // Level flag re-sets after a clear while the condition persists
  assign fifo_level = (tx_active && (fifo_count < `RIF_TX_LOW_LVL)) ||
    (rx_active && (fifo_count > `RIF_RX_HIGH_LVL));

  // ----------------------------------------------------------------
  // Event set vectors, independent of the enables
  // ----------------------------------------------------------------
  always @*
  begin
    set1 = `RIF_ZERO8;
    set2 = `RIF_ZERO8;
    set1[`RIF_B_TX] = tx_done;
    set1[`RIF_B_RX] = rx_done;
    set1[`RIF_B_FIFO] = fifo_level;
    set1[`RIF_B_ERR] = any_err;
    set1[`RIF_B_HDR] = direct_fifo_second_byte_option ?
      second_byte_evt : header_bit_high;
    set1[`RIF_B_AACK] = automatic_acknowledge_procedure_success ||
      (automatic_acknowledge_procedure &&
      (noresp_expired || any_err));
    set1[`RIF_B_NORESP] = noresp_expired;
    set2[`RIF_B_ANA] = ana_change;
    set2[`RIF_B_CMD] = cmd_done;
    set2[`RIF_B_CRC] = crc_fault;
    set2[`RIF_B_LEN] = length_fault;
    set2[`RIF_B_PRE] = preamble_fault;
  end

  // ----------------------------------------------------------------
  // Read mux; flags read back only implemented bits
  // ----------------------------------------------------------------
  always @*
  begin
    rd_byte = `RIF_ZERO8;
    rd_hit = 1'b1;
    case (raidx)
      `RIF_IDX_EN1: rd_byte = en1_ff;
      `RIF_IDX_EN2: rd_byte = en2_ff;
      `RIF_IDX_F1: rd_byte = f1_ff & `RIF_F1_MASK;
      `RIF_IDX_F2: rd_byte = f2_ff & `RIF_F2_MASK;
      default: rd_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always @*
  begin
    nxt_en1 = en1_ff;
    nxt_en2 = en2_ff;
    nxt_snap1 = snap1_ff;
    nxt_snap2 = snap2_ff;
    nxt_aw_held = aw_held_ff;
    nxt_w_held = w_held_ff;
    nxt_waidx = waidx_ff;
    nxt_wbyte = wbyte_ff;
    nxt_wstrb0 = wstrb0_ff;
    nxt_bresp = s_axi_bresp;
    nxt_bvalid = s_axi_bvalid;
    nxt_rdata = s_axi_rdata;
    nxt_rresp = s_axi_rresp;
    nxt_rvalid = s_axi_rvalid;
    // Address and data are caught in either order
    if (aw_take)
    begin
      nxt_aw_held = 1'b1;
      nxt_waidx = s_axi_awaddr[`RIF_ADDR_HI:`RIF_ADDR_LO];
    end
    if (w_take)
    begin
      nxt_w_held = 1'b1;
      nxt_wbyte = s_axi_wdata[7:0];
      nxt_wstrb0 = s_axi_wstrb[0];
    end
    // Write commits once both halves are in; flags are read-only
    if (do_write)
    begin
      nxt_aw_held = 1'b0;
      nxt_w_held = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = `RIF_RESP_OKAY;
      case (waidx_ff)
        `RIF_IDX_EN1:
        begin
          if (wstrb0_ff)
          begin
            nxt_en1 = (wbyte_ff & `RIF_EN1_WMASK) | `RIF_EN1_FIXED;
          end
        end
        `RIF_IDX_EN2:
        begin
          if (wstrb0_ff)
          begin
            nxt_en2 = wbyte_ff & `RIF_EN2_WMASK;
          end
        end
        `RIF_IDX_F1: nxt_bresp = `RIF_RESP_OKAY;
        `RIF_IDX_F2: nxt_bresp = `RIF_RESP_OKAY;
        default: nxt_bresp = `RIF_RESP_SLVERR;
      endcase
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      nxt_bvalid = 1'b0;
    end
    // Snapshot at capture so late events survive the clear
    if (ar_take)
    begin
      nxt_rvalid = 1'b1;
      nxt_rdata = {24'h00_0000, rd_byte};
      nxt_rresp = rd_hit ? `RIF_RESP_OKAY : `RIF_RESP_SLVERR;
      nxt_snap1 = (raidx == `RIF_IDX_F1) ? f1_ff : `RIF_ZERO8;
      nxt_snap2 = (raidx == `RIF_IDX_F2) ? f2_ff : `RIF_ZERO8;
    end
    else if (r_done)
    begin
      nxt_rvalid = 1'b0;
    end
    nxt_awready = !nxt_aw_held;
    nxt_wready = !nxt_w_held;
    nxt_arready = !nxt_rvalid;
    // Clear at end of read phase, only bits the host has seen
    clr1 = r_done ? snap1_ff : `RIF_ZERO8;
    clr2 = r_done ? snap2_ff : `RIF_ZERO8;
    // Set wins over read clear; enable low holds both flag registers at zero
    if (!chip_en)
    begin
      nxt_f1 = `RIF_ZERO8;
      nxt_f2 = `RIF_ZERO8;
    end
    else
    begin
      nxt_f1 = ((f1_ff & ~clr1) | set1) & `RIF_F1_MASK;
      nxt_f2 = ((f2_ff & ~clr2) | set2) & `RIF_F2_MASK;
    end
    // Pin follows enabled pending flags of both registers
    nxt_irq = |(nxt_f1 & en1_ff & `RIF_F1_MASK) ||
      |(nxt_f2 & en2_ff & `RIF_F2_MASK);
    // Timer aborts receive only when its enable is set
    nxt_rx_abort = noresp_expired && en1_ff[`RIF_B_NORESP];
  end

  // ----------------------------------------------------------------
  // Registers; power-up reset and clock-enable freeze
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en1_ff <= `RIF_EN1_RST;
      en2_ff <= `RIF_EN2_RST;
      f1_ff <= `RIF_ZERO8;
      f2_ff <= `RIF_ZERO8;
      snap1_ff <= `RIF_ZERO8;
      snap2_ff <= `RIF_ZERO8;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      waidx_ff <= `RIF_ZERO8;
      wbyte_ff <= `RIF_ZERO8;
      wstrb0_ff <= 1'b0;
      irq <= 1'b0;
      rx_abort <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bresp <= `RIF_RESP_OKAY;
      s_axi_bvalid <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RIF_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
    end
    else if (ce)
    begin
      en1_ff <= nxt_en1;
      en2_ff <= nxt_en2;
      f1_ff <= nxt_f1;
      f2_ff <= nxt_f2;
      snap1_ff <= nxt_snap1;
      snap2_ff <= nxt_snap2;
      aw_held_ff <= nxt_aw_held;
      w_held_ff <= nxt_w_held;
      waidx_ff <= nxt_waidx;
      wbyte_ff <= nxt_wbyte;
      wstrb0_ff <= nxt_wstrb0;
      irq <= nxt_irq;
      rx_abort <= nxt_rx_abort;
      s_axi_awready <= nxt_awready;
      s_axi_wready <= nxt_wready;
      s_axi_bresp <= nxt_bresp;
      s_axi_bvalid <= nxt_bvalid;
      s_axi_arready <= nxt_arready;
      s_axi_rdata <= nxt_rdata;
      s_axi_rresp <= nxt_rresp;
      s_axi_rvalid <= nxt_rvalid;
    end
  end
endmodule // rif_top

// file: rif_assertions.sv
`timescale 1ns/1ns
// ----------------------------------------
// Pin and register bus checks
// ----------------------------------------
module rif_assertions (
  input wire aclk,
  input wire aresetn,
  input wire irq,
  input wire rx_abort,
  input wire noresp_expired,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Handshake steps that start a bus answer
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_abort_after_expiry: assert property (rx_abort |->
    $past(noresp_expired))
    else $error("abort without timer expiry");
  a_abort_one_cycle: assert property (rx_abort |=> !rx_abort)
    else $error("abort longer than one cycle");
  a_irq_reset_low: assert property ($rose(aresetn) |-> !irq)
    else $error("irq high out of reset");
  a_write_answer: assert property (s_wr_taken |-> ##[2:3] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_rd_taken |-> ##[1:2] s_axi_rvalid)
    else $error("read data late");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_rdata_upper_zero: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_bresp_code: assert property (s_axi_bvalid |->
    (s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2))
    else $error("bad write response code");
endmodule // rif_assertions

bind rif_top rif_assertions u_chk (.aclk, .aresetn, .irq, .rx_abort,
  .noresp_expired, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready);

// file: rif_host.sv
`timescale 1ns/1ns
// ----------------------------------------
// Host controller model, bus master
// ----------------------------------------
module rif_host (
  input wire aclk,
  output reg [11:0] s_axi_awaddr,
  output reg s_axi_awvalid,
  input wire s_axi_awready,
  output reg [31:0] s_axi_wdata,
  output reg [3:0] s_axi_wstrb,
  output reg s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  output reg s_axi_bready,
  output reg [11:0] s_axi_araddr,
  output reg s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  output reg s_axi_rready
);
  // Quiet bus at time zero
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
  end

  // Write; bready rises with the request and is held until the answer
  task wr(input [11:0] a, input [7:0] d, output [1:0] r);
    reg dn;
    dn = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!dn)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        dn = 1'b1;
      end
    end
  endtask

  // Read; rready held from the request until data is taken
  task rd(input [11:0] a, output [31:0] d, output [1:0] r);
    reg dn;
    dn = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!dn)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        dn = 1'b1;
      end
    end
  endtask
endmodule // rif_host

// file: test_reader_irq_flags_and_masks.sv
`timescale 1ns/1ns
// ----------------------------------------
// Flag and mask bench
// ----------------------------------------
module test_reader_irq_flags_and_masks;
  // Expected {flag2, flag1} per event line k
  localparam [175:0] EXP = {16'h4000, 16'h8000, 16'h0000, 16'h0080,
    16'h0040, 16'h0110, 16'h0410, 16'h0008, 16'h0210, 16'h0002, 16'h0001};
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg chip_en = 1'b0;
  reg opt = 1'b0;
  reg aap = 1'b0;
  reg txa = 1'b0;
  reg rxa = 1'b0;
  reg [4:0] cnt = 5'h00;
  reg [10:0] ev = 11'h000;
  reg [3:0] aborts = 4'h0;
  reg [31:0] d;
  reg [1:0] r;
  integer err_count = 0;
  integer compares = 0;
  wire [11:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire irq, rx_abort, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  wire s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  wire s_axi_arready, s_axi_rvalid, s_axi_rready;

  // System clock
  always #5 aclk = ~aclk;
  // Count abort pulses on the pin
  always @(posedge aclk)
  begin
    if (rx_abort === 1'b1)
      aborts <= aborts + 4'h1;
  end

  rif_top DUT (.aclk, .aresetn, .ce(1'b1), .chip_en_pin(chip_en),
    .tx_done(ev[7]), .rx_done(ev[6]), .tx_active(txa), .rx_active(rxa),
    .fifo_count(cnt), .crc_fault(ev[4]), .length_fault(ev[2]),
    .preamble_fault(ev[5]), .header_bit_high(ev[3]),
    .second_byte_evt(ev[8]), .direct_fifo_second_byte_option(opt),
    .automatic_acknowledge_procedure(aap), .automatic_acknowledge_procedure_success(ev[1]),
    .noresp_expired(ev[0]), .ana_change(ev[9]), .cmd_done(ev[10]), .irq,
    .rx_abort, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  rif_host host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    compares = compares + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("Error %0s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wrap_up;
    if (err_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Settle past the clearing edge before judging
  task rdf(input [11:0] a, input [31:0] e, input string nm);
    host.rd(a, d, r);
    #1;
    chk(nm, d, e);
  endtask

  task pulse(input [10:0] v);
    @(posedge aclk);
    ev <= v;
    @(posedge aclk);
    ev <= 11'h000;
    repeat (3) @(posedge aclk);
    #1;
  endtask

  task fifo(input t, input [4:0] c, input [7:0] e);
    @(posedge aclk);
    txa <= t;
    rxa <= !t;
    cnt <= c;
    repeat (3) @(posedge aclk);
    host.rd(12'h0DC, d, r);
    rdf(12'h0DC, {24'h00_0000, e}, "fifo level");
  endtask

  task t_regs;
    rdf(12'h0D4, 32'h0000_00F7, "en1");
    rdf(12'h0D8, 32'h0000_0040, "en2");
    host.wr(12'h0DC, 8'hFF, r);
    chk("flag write resp", r, 32'h0000_0000);
    rdf(12'h0DC, 32'h0000_0000, "flag1 after write");
    host.wr(12'h0D8, 8'hC7, r);
    rdf(12'h0D8, 32'h0000_00C7, "en2 write");
    host.wr(12'h0D8, 8'h40, r);
    host.rd(12'h0FC, d, r);
    chk("unmapped resp", r, 32'h0000_0002);
  endtask

  task t_events;
    integer k;
    reg [15:0] x;
    for (k = 0; k < 11; k = k + 1)
    begin
      x = EXP[16*k +: 16];
      pulse(11'h001 << k);
      chk("irq", irq, |(x & 16'h40F7));
      rdf(12'h0DC, {24'h00_0000, x[7:0]}, "flag1");
      rdf(12'h0E0, {24'h00_0000, x[15:8]}, "flag2");
      chk("irq after read", irq, 32'h0000_0000);
    end
    chk("aborts", aborts, 32'h0000_0001);
  endtask

  task t_special;
    fifo(1'b1, 5'h05, 8'h20);
    fifo(1'b1, 5'h06, 8'h00);
    fifo(1'b0, 5'h13, 8'h20);
    fifo(1'b0, 5'h12, 8'h00);
    @(posedge aclk);
    rxa <= 1'b0;
    opt <= 1'b1;
    pulse(11'h100);
    rdf(12'h0DC, 32'h0000_0008, "second byte");
    pulse(11'h008);
    rdf(12'h0DC, 32'h0000_0000, "header muted");
    @(posedge aclk);
    opt <= 1'b0;
    aap <= 1'b1;
    pulse(11'h010);
    rdf(12'h0DC, 32'h0000_0012, "ack on fault");
    rdf(12'h0E0, 32'h0000_0004, "crc sub flag");
    @(posedge aclk);
    aap <= 1'b0;
  endtask

  task t_masks;
    host.wr(12'h0D4, 8'h00, r);
    pulse(11'h080);
    chk("masked irq", irq, 32'h0000_0000);
    pulse(11'h001);
    chk("aborts masked", aborts, 32'h0000_0001);
    host.wr(12'h0D4, 8'h80, r);
    repeat (2) @(posedge aclk);
    #1;
    chk("unmasked irq", irq, 32'h0000_0001);
    rdf(12'h0DC, 32'h0000_0081, "masked flags");
    chk("irq cleared", irq, 32'h0000_0000);
    host.wr(12'h0D4, 8'hF7, r);
  endtask

  task t_chip_off;
    pulse(11'h080);
    chk("irq pending", irq, 32'h0000_0001);
    @(posedge aclk);
    chip_en <= 1'b0;
    repeat (6) @(posedge aclk);
    #1;
    chk("irq chip off", irq, 32'h0000_0000);
    rdf(12'h0DC, 32'h0000_0000, "flag1 chip off");
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    chip_en <= 1'b1;
    repeat (8) @(posedge aclk);
    t_regs;
    t_events;
    t_special;
    t_masks;
    t_chip_off;
    wrap_up;
  end

  // Watchdog, far beyond the expected run
  initial
  begin
    repeat (5000) @(posedge aclk);
    err_count = err_count + 1;
    wrap_up;
  end
endmodule // test_reader_irq_flags_and_masks
